// ==== rtl/mmb_pkg.sv ====
// package: opcodes, widths and reset values for the move and branch executor
package mmb_pkg;

  // ****************************************
  // data path widths
  // ****************************************
  localparam int DATA_W = 8;
  localparam int PC_W = 10;
  localparam int FILE_AW = 6;
  localparam int IO_AW = 4;

  // ****************************************
  // operand ranges
  // ****************************************
  localparam logic [IO_AW-1:0] IO_READ_MIN = 4'h5;
  localparam logic [IO_AW-1:0] IO_READ_MAX = 4'hf;
  localparam logic [IO_AW-1:0] IO_WRITE_MIN = 4'h0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [DATA_W-1:0] WORKING_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 10'h000;
  localparam logic RESULT_NULL_RST = 1'b0;

  // ****************************************
  // cycle counts
  // ****************************************
  localparam int LONG_OP_CYCLES = 2;
  localparam int SHORT_OP_CYCLES = 1;

  // ****************************************
  // operation codes presented by the decoder
  // ****************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_OR_IMMEDIATE = 4'h1,
    OP_IO_PAGE_READ = 4'h2,
    OP_IO_PAGE_WRITE = 4'h3,
    OP_LONG_CALL = 4'h4,
    OP_LONG_JUMP = 4'h5,
    OP_LOAD_IMMEDIATE = 4'h6,
    OP_STORE_WORKING = 4'h7,
    OP_COPY_FILE = 4'h8
  } mmb_op_t;

  // ****************************************
  // executor states
  // ****************************************
  typedef enum logic {
    ST_EXEC = 1'b0,
    ST_SETTLE = 1'b1
  } mmb_state_t;

endpackage

// ==== rtl/mmb_slot_array.sv ====
// slot array: single write port, asynchronous read port
`timescale 1ns/100ps
`default_nettype none
module mmb_slot_array #(
  parameter int WIDTH = 8,
  parameter int ADDR_W = 6
) (
  // clock
  input wire logic clock,
  // write port
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  // read port
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] slots [0:(1<<ADDR_W)-1];

  // elaboration check on shape
  initial begin
    if (WIDTH < 1 || ADDR_W < 1 || ADDR_W > 12) begin
      $error("mmb_slot_array: unsupported shape");
    end
  end

  // storage write, no reset on contents
  always_ff @(posedge clock) begin
    if (wrEn) begin
      slots[wrAddr] <= wrData;
    end
  end

  // combinational read
  assign rdData = slots[rdAddr];

endmodule
`default_nettype wire

// ==== rtl/mmb_executor.sv ====
// executor for immediate, i/o page, file copy and long branch operations
`timescale 1ns/100ps
`default_nettype none
module mmb_executor
  import mmb_pkg::*;
#(
  parameter int FILE_DEPTH = 64,
  parameter int IO_DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // decoded instruction from program memory
  input wire logic instrValid,
  input wire mmb_op_t instrOp,
  input wire logic [PC_W-1:0] instrOperand,
  input wire logic targetChoice,
  output logic instrReady,
  // architectural state
  output logic [DATA_W-1:0] workingLatch,
  output logic resultNullFlag,
  output logic [PC_W-1:0] programCounter,
  // stack push towards the return stack
  output logic stackPush,
  output logic [PC_W-1:0] stackData,
  // i/o page write notification to peripherals
  output logic ioWriteStrobe,
  output logic [IO_AW-1:0] ioWriteIndex,
  output logic [DATA_W-1:0] ioWriteData,
  // operand out of range seen
  output logic operandRefused
);

  // ****************************************
  // elaboration checks
  // ****************************************
  initial begin
    if (FILE_DEPTH != (1 << FILE_AW) || IO_DEPTH != (1 << IO_AW)) begin
      $error("mmb_executor: depths must match operand widths");
    end
  end

  // ****************************************
  // helper functions
  // ****************************************
  // zero test on an 8-bit result
  function automatic logic isNull(input logic [DATA_W-1:0] value);
    isNull = (value == '0);
  endfunction

  // operations that take two cycles
  function automatic logic isLongOp(input mmb_op_t op);
    isLongOp = (op == OP_LONG_CALL) || (op == OP_LONG_JUMP);
  endfunction

  // ****************************************
  // state and signals
  // ****************************************
  mmb_state_t state_reg, state_next;
  logic [DATA_W-1:0] working_reg;
  logic nullFlag_reg;
  logic [PC_W-1:0] pc_reg;
  logic stackPush_reg;
  logic [PC_W-1:0] stackData_reg;
  logic ioStrobe_reg;
  logic [IO_AW-1:0] ioIndex_reg;
  logic [DATA_W-1:0] ioData_reg;
  logic refused_reg;
  logic ready_reg;

  logic accept;
  logic [DATA_W-1:0] immediate;
  logic [FILE_AW-1:0] fileAddr;
  logic [IO_AW-1:0] ioIndex;
  logic [DATA_W-1:0] fileRdData;
  logic [DATA_W-1:0] ioRdData;
  logic ioReadOk;
  logic fileWrEn;
  logic [DATA_W-1:0] fileWrData;
  logic ioWrEn;
  logic [PC_W-1:0] pcPlusOne;

  // ****************************************
  // operand fields
  // ****************************************
  assign accept = instrValid && ready_reg;
  assign immediate = instrOperand[DATA_W-1:0];
  assign fileAddr = instrOperand[FILE_AW-1:0];
  assign ioIndex = instrOperand[IO_AW-1:0];
  assign pcPlusOne = pc_reg + 10'h001;
  assign ioReadOk = (ioIndex >= IO_READ_MIN) && (ioIndex <= IO_READ_MAX);

  // ****************************************
  // storage write selection
  // ****************************************
  // store working writes the latch, copy with choice 1 writes the slot back
  always_comb begin
    fileWrEn = 1'b0;
    fileWrData = working_reg;
    if (accept && instrOp == OP_STORE_WORKING) begin
      fileWrEn = 1'b1;
    end else if (accept && instrOp == OP_COPY_FILE && targetChoice) begin
      fileWrEn = 1'b1;
      fileWrData = fileRdData;
    end
  end

  // every index 0..15 is writable, so no range test is needed
  assign ioWrEn = accept && (instrOp == OP_IO_PAGE_WRITE);

  // file slots
  mmb_slot_array #(
    .WIDTH(DATA_W),
    .ADDR_W(FILE_AW)
  ) fileSlots (
    .clock(clock),
    .wrEn(fileWrEn),
    .wrAddr(fileAddr),
    .wrData(fileWrData),
    .rdAddr(fileAddr),
    .rdData(fileRdData)
  );

  // i/o page special function registers
  mmb_slot_array #(
    .WIDTH(DATA_W),
    .ADDR_W(IO_AW)
  ) ioPage (
    .clock(clock),
    .wrEn(ioWrEn),
    .wrAddr(ioIndex),
    .wrData(working_reg),
    .rdAddr(ioIndex),
    .rdData(ioRdData)
  );

  // ****************************************
  // sequencing
  // ****************************************
  // long ops hold off the next instruction for one settle cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_EXEC: begin
        if (accept && isLongOp(instrOp)) begin
          state_next = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        state_next = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= ST_EXEC;
    end else begin
      state_reg <= state_next;
    end
  end

  // ready follows next state so it is a plain flop
  always_ff @(posedge clock) begin
    if (srst) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_next == ST_EXEC);
    end
  end

  // ****************************************
  // working latch
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      working_reg <= WORKING_RST;
    end else if (accept) begin
      unique case (instrOp)
        OP_OR_IMMEDIATE: working_reg <= working_reg | immediate;
        OP_LOAD_IMMEDIATE: working_reg <= immediate;
        OP_IO_PAGE_READ: begin
          if (ioReadOk) begin
            working_reg <= ioRdData;
          end
        end
        OP_COPY_FILE: begin
          if (!targetChoice) begin
            working_reg <= fileRdData;
          end
        end
        default: working_reg <= working_reg;
      endcase
    end
  end

  // ****************************************
  // result null flag
  // ****************************************
  // only or immediate and copy file touch the flag
  always_ff @(posedge clock) begin
    if (srst) begin
      nullFlag_reg <= RESULT_NULL_RST;
    end else if (accept && instrOp == OP_OR_IMMEDIATE) begin
      nullFlag_reg <= isNull(working_reg | immediate);
    end else if (accept && instrOp == OP_COPY_FILE) begin
      nullFlag_reg <= isNull(fileRdData);
    end
  end

  // ****************************************
  // program counter
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      pc_reg <= PC_RST;
    end else if (accept) begin
      if (isLongOp(instrOp)) begin
        pc_reg <= instrOperand;
      end else begin
        pc_reg <= pcPlusOne;
      end
    end
  end

  // ****************************************
  // stack push
  // ****************************************
  // only the call pushes; the jump leaves the stack alone
  always_ff @(posedge clock) begin
    if (srst) begin
      stackPush_reg <= 1'b0;
      stackData_reg <= PC_RST;
    end else begin
      stackPush_reg <= accept && (instrOp == OP_LONG_CALL);
      if (accept && instrOp == OP_LONG_CALL) begin
        stackData_reg <= pcPlusOne;
      end
    end
  end

  // ****************************************
  // i/o page write notification
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      ioStrobe_reg <= 1'b0;
      ioIndex_reg <= '0;
      ioData_reg <= WORKING_RST;
    end else begin
      ioStrobe_reg <= ioWrEn;
      if (ioWrEn) begin
        ioIndex_reg <= ioIndex;
        ioData_reg <= working_reg;
      end
    end
  end

  // ****************************************
  // refused operand
  // ****************************************
  // read of page index below 5 leaves the latch unchanged
  always_ff @(posedge clock) begin
    if (srst) begin
      refused_reg <= 1'b0;
    end else begin
      refused_reg <= accept && (instrOp == OP_IO_PAGE_READ) && !ioReadOk;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign instrReady = ready_reg;
  assign workingLatch = working_reg;
  assign resultNullFlag = nullFlag_reg;
  assign programCounter = pc_reg;
  assign stackPush = stackPush_reg;
  assign stackData = stackData_reg;
  assign ioWriteStrobe = ioStrobe_reg;
  assign ioWriteIndex = ioIndex_reg;
  assign ioWriteData = ioData_reg;
  assign operandRefused = refused_reg;

endmodule
`default_nettype wire

// ==== test/mmb_executor_monitor.sv ====
// checker: timing and data relations at the executor ports
`timescale 1ns/100ps
`default_nettype none
module mmb_executor_monitor
  import mmb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // instruction side
  input wire logic instrValid,
  input wire mmb_op_t instrOp,
  input wire logic [PC_W-1:0] instrOperand,
  input wire logic targetChoice,
  input wire logic instrReady,
  // state and strobes
  input wire logic [DATA_W-1:0] workingLatch,
  input wire logic resultNullFlag,
  input wire logic [PC_W-1:0] programCounter,
  input wire logic stackPush,
  input wire logic [PC_W-1:0] stackData,
  input wire logic ioWriteStrobe,
  input wire logic [IO_AW-1:0] ioWriteIndex,
  input wire logic [DATA_W-1:0] ioWriteData,
  input wire logic operandRefused
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic take;
  // instruction taken at this edge
  assign take = instrValid && instrReady;
  a_or_imm: assert property (take && instrOp == OP_OR_IMMEDIATE |=>
    workingLatch == ($past(workingLatch) | $past(instrOperand[7:0])) && resultNullFlag == (workingLatch == 8'h00))
    else $error("or immediate result wrong");
  a_load_imm: assert property (take && instrOp == OP_LOAD_IMMEDIATE |=>
    workingLatch == $past(instrOperand[7:0]) && $stable(resultNullFlag)) else $error("load immediate wrong");
  a_call_push: assert property (take && instrOp == OP_LONG_CALL |=>
    stackPush && !instrReady && stackData == $past(programCounter) + 10'h001 && programCounter == $past(instrOperand))
    else $error("long call wrong");
  a_jump_load: assert property (take && instrOp == OP_LONG_JUMP |=>
    programCounter == $past(instrOperand) && !stackPush && !instrReady && $stable(resultNullFlag) ##1 instrReady)
    else $error("long jump wrong");
  a_io_write: assert property (take && instrOp == OP_IO_PAGE_WRITE |=>
    ioWriteStrobe && ioWriteIndex == $past(instrOperand[3:0]) && ioWriteData == $past(workingLatch))
    else $error("io page write wrong");
  a_io_refuse: assert property (take && instrOp == OP_IO_PAGE_READ && instrOperand[3:0] < IO_READ_MIN |=>
    operandRefused && $stable(workingLatch)) else $error("io read refusal wrong");
  a_io_flags: assert property (take && (instrOp == OP_IO_PAGE_READ || instrOp == OP_IO_PAGE_WRITE) |=>
    $stable(resultNullFlag)) else $error("io op changed flag");
  a_store_keep: assert property (take && instrOp == OP_STORE_WORKING |=>
    $stable(workingLatch) && $stable(resultNullFlag) && programCounter == $past(programCounter) + 10'h001)
    else $error("store working wrong");
  a_copy_flag: assert property (take && instrOp == OP_COPY_FILE |=>
    (resultNullFlag == (workingLatch == 8'h00) || $past(targetChoice)) && (!$past(targetChoice) || $stable(workingLatch)))
    else $error("copy file wrong");
endmodule
bind mmb_executor mmb_executor_monitor i_mmb_executor_monitor (.clock, .srst, .instrValid, .instrOp, .instrOperand,
  .targetChoice, .instrReady, .workingLatch, .resultNullFlag, .programCounter, .stackPush, .stackData,
  .ioWriteStrobe, .ioWriteIndex, .ioWriteData, .operandRefused);
`default_nettype wire

// ==== test/mmb_prog_source.sv ====
// program memory model: presents instruction words, scrambles idle operands
`timescale 1ns/100ps
`default_nettype none
module mmb_prog_source
  import mmb_pkg::*;
(
  // bench side
  input wire logic clock,
  input wire logic go,
  input wire mmb_op_t wordOp,
  input wire logic [PC_W-1:0] wordOperand,
  input wire logic wordChoice,
  // executor side
  output logic instrValid,
  output mmb_op_t instrOp,
  output logic [PC_W-1:0] instrOperand,
  output logic targetChoice
);
  logic [PC_W-1:0] lastOperand_reg = 10'h2aa;
  // remember last word, flip it while idle
  always_ff @(posedge clock) begin
    lastOperand_reg <= go ? wordOperand : ~lastOperand_reg;
  end
  // idle lines show the last word inverted, then return to it on every second idle cycle
  assign instrValid = go;
  assign instrOp = go ? wordOp : OP_NONE;
  assign instrOperand = go ? wordOperand : ~lastOperand_reg;
  assign targetChoice = go ? wordChoice : ~lastOperand_reg[0];
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// testbench: table of one-cycle ops, then refusal and long branches
`timescale 1ns/100ps
`default_nettype none
module testbench
  import mmb_pkg::*;
;
  typedef struct {mmb_op_t op; logic [PC_W-1:0] arg; logic d; logic [DATA_W-1:0] acc; logic zf;} mmb_row_t;
  logic clock = 1'b0, srst = 1'b1, go = 1'b0, wordChoice = 1'b0;
  mmb_op_t wordOp = OP_NONE;
  logic [PC_W-1:0] wordOperand = 10'h000;
  logic instrValid, targetChoice, instrReady, resultNullFlag, stackPush, ioWriteStrobe, operandRefused;
  mmb_op_t instrOp;
  logic [PC_W-1:0] instrOperand, programCounter, stackData;
  logic [DATA_W-1:0] workingLatch, ioWriteData;
  logic [IO_AW-1:0] ioWriteIndex;
  int num_errors = 0, samples_checked = 0;
  mmb_row_t rows [12] = '{'{OP_LOAD_IMMEDIATE, 10'h055, 1'b0, 8'h55, 1'b0}, '{OP_STORE_WORKING, 10'h003, 1'b0, 8'h55, 1'b0},
    '{OP_LOAD_IMMEDIATE, 10'h000, 1'b0, 8'h00, 1'b0}, '{OP_OR_IMMEDIATE, 10'h000, 1'b0, 8'h00, 1'b1},
    '{OP_IO_PAGE_WRITE, 10'h009, 1'b0, 8'h00, 1'b1}, '{OP_STORE_WORKING, 10'h03f, 1'b0, 8'h00, 1'b1},
    '{OP_LOAD_IMMEDIATE, 10'h0aa, 1'b0, 8'haa, 1'b1}, '{OP_IO_PAGE_READ, 10'h009, 1'b0, 8'h00, 1'b1},
    '{OP_COPY_FILE, 10'h003, 1'b0, 8'h55, 1'b0}, '{OP_COPY_FILE, 10'h03f, 1'b1, 8'h55, 1'b1},
    '{OP_OR_IMMEDIATE, 10'h0a0, 1'b0, 8'hf5, 1'b0}, '{OP_COPY_FILE, 10'h03f, 1'b0, 8'h00, 1'b1}};
  // clock at 20 mhz
  always #25 clock = ~clock;
  mmb_prog_source i_mmb_prog_source (.clock, .go, .wordOp, .wordOperand, .wordChoice, .instrValid, .instrOp,
    .instrOperand, .targetChoice);
  mmb_executor i_mmb_executor (.clock, .srst, .instrValid, .instrOp, .instrOperand, .targetChoice, .instrReady,
    .workingLatch, .resultNullFlag, .programCounter, .stackPush, .stackData, .ioWriteStrobe, .ioWriteIndex,
    .ioWriteData, .operandRefused);
  // verdict and end of run
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // compare one value
  task chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // present a word, let one edge take it
  task step(input mmb_op_t op, input logic [PC_W-1:0] arg, input logic d);
    go = 1'b1;
    wordOp = op;
    wordOperand = arg;
    wordChoice = d;
    @(posedge clock);
    #1;
  endtask
  // long op, then a load held through the settle cycle
  task long_op(input mmb_op_t op, input logic [PC_W-1:0] tgt, input logic push, input logic [PC_W-1:0] ret);
    step(op, tgt, 1'b0);
    chk(programCounter, tgt);
    chk(stackPush, push);
    if (push) chk(stackData, ret);
    chk(instrReady, 1'b0);
    step(OP_LOAD_IMMEDIATE, 10'h033, 1'b0);
    chk(programCounter, tgt);
    chk(stackPush, 1'b0);
    step(OP_LOAD_IMMEDIATE, 10'h033, 1'b0);
    chk(workingLatch, 10'h033);
    chk(programCounter, tgt + 10'h001);
    $display("long op %0d done", op);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    #1 srst = 1'b0;
    chk(workingLatch, 10'h000);
    chk(programCounter, 10'h000);
    chk(resultNullFlag, 1'b0);
    chk(instrReady, 1'b0);
    for (int i = 0; i < 8 && instrReady !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    if (instrReady !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: never ready", $time);
    end
    $display("reset done");
    foreach (rows[i]) begin
      step(rows[i].op, rows[i].arg, rows[i].d);
      chk(workingLatch, rows[i].acc);
      chk(resultNullFlag, rows[i].zf);
    end
    chk(programCounter, 10'h00c);
    $display("table done");
    step(OP_IO_PAGE_READ, 10'h004, 1'b0);
    chk(operandRefused, 1'b1);
    chk(workingLatch, 10'h000);
    $display("refusal done");
    long_op(OP_LONG_JUMP, 10'h3ff, 1'b0, 10'h000);
    long_op(OP_LONG_CALL, 10'h155, 1'b1, 10'h001);
    // mid-run reset while a load is still offered
    srst = 1'b1;
    @(posedge clock);
    #1;
    chk(workingLatch, 10'h000);
    chk(programCounter, 10'h000);
    chk(resultNullFlag, 1'b0);
    chk(instrReady, 1'b0);
    srst = 1'b0;
    @(posedge clock);
    #1;
    chk(workingLatch, 10'h000);
    chk(programCounter, 10'h000);
    chk(instrReady, 1'b1);
    $display("second reset done");
    go = 1'b0;
    @(posedge clock);
    report_and_stop;
  end
endmodule
`default_nettype wire
